// File: mipu_core.sv
`timescale 1ns/1ps
`default_nettype none
module mipu_core
  import mipu_pkg::*;
#(
  parameter int KEY_LINES = MIPU_KEY_LINES
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  input wire mipu_timer_src_t timer_src,
  input wire logic [KEY_LINES-1:0] key_line_flag,
  input wire logic [KEY_LINES-1:0] key_line_int_enable,
  input wire logic watchdog_expired,
  input wire logic power_on_event,
  input wire logic pin_reset_req,
  input wire logic insn_boundary,
  input wire logic soft_trap_instr,
  input wire logic trap_return_instr,
  input wire logic cpu_waiting,
  input wire mipu_cpu_regs_t cpu_regs,
  input wire logic [7:0] stack_rdata,
  output mipu_stack_bus_t stack_bus_q,
  output logic [15:0] vector_addr_q,
  output logic vector_fetch_q,
  output logic int_mask_q,
  output logic seq_busy_q,
  output logic wake_q,
  output mipu_cpu_regs_t restore_regs_q,
  output logic restore_valid_q,
  output logic cpu_reset_q,
  output logic compare_pin_enable,
  output logic capture_pin_enable
);
  logic [7:0] mcs_q, mcs_d;
  logic ext_latch_q, ext_latch_d;
  logic pin_prev_q, pin_prev_d;
  logic [7:0] rdata_q, rdata_d;
  mipu_state_t st_q, st_d;
  mipu_src_t src_q, src_d, pick;
  logic [5:0] sp_q, sp_d;
  logic mask_q, mask_d;
  mipu_stack_bus_t sb_d;
  logic [15:0] vec_q, vec_d;
  logic vf_d;
  mipu_cpu_regs_t rr_q, rr_d;
  logic rv_d, wake_d, rst_d, rst_q;
  logic rd_dly_q, rd_dly_d;
  logic ext_en, sense, fall, ext_req, tim16_req, tim8_req, key_req, reset_req, any_masked;

  assign ext_en = mcs_q[MIPU_BIT_EXT_EN];
  assign sense = mcs_q[MIPU_BIT_SENSE];
  assign fall = pin_prev_q & ~pin_in;
  assign tim16_req = (timer_src.capture_flag & timer_src.capture_int_enable)
    | (timer_src.compare_flag & timer_src.compare_int_enable)
    | (timer_src.overflow_flag & timer_src.overflow_int_enable);
  assign tim8_req = timer_src.short_timer_flag & timer_src.short_timer_int_enable;
  assign key_req = |(key_line_flag & key_line_int_enable);
  assign reset_req = power_on_event | pin_reset_req | (watchdog_expired & mcs_q[MIPU_BIT_WDOG]);
  assign ext_req = ext_latch_q & ext_en;
  assign any_masked = ext_req | tim16_req | tim8_req | key_req;

  // register port and pin latch
  always_comb
  begin
    mcs_d = mcs_q;
    rdata_d = 8'h00;
    pin_prev_d = pin_in;
    ext_latch_d = ext_latch_q;
    if (reg_wr && reg_addr == MIPU_MCS_OFFSET)
    begin
      // power-on flag is cleared by a software write of 0 or by reset_n; a write of 1 leaves it
      mcs_d = (reg_wdata & MIPU_MCS_WMASK) | (mcs_q & ~MIPU_MCS_WMASK);
      if (!reg_wdata[MIPU_BIT_POR])
        mcs_d[MIPU_BIT_POR] = 1'b0;
    end
    if (power_on_event)
      mcs_d[MIPU_BIT_POR] = 1'b1;
    if (reg_rd && reg_addr == MIPU_MCS_OFFSET)
      rdata_d = mcs_q;
    if (st_q == MIPU_ST_VEC_HI && src_q == MIPU_SRC_EXT)
      ext_latch_d = 1'b0;
    if (ext_en)
    begin
      if (fall || (!sense && !pin_in))
        ext_latch_d = 1'b1; // set wins over vector-fetch clear
    end
    else
      ext_latch_d = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mcs_q <= MIPU_MCS_RESET;
      rdata_q <= 8'h00;
      pin_prev_q <= 1'b1;
      ext_latch_q <= 1'b0;
    end
    else if (clk_en)
    begin
      mcs_q <= mcs_d;
      rdata_q <= rdata_d;
      pin_prev_q <= pin_prev_d;
      ext_latch_q <= ext_latch_d;
    end
  end

  always_comb
  begin
    if (reset_req)
      pick = MIPU_SRC_RESET;
    else if (soft_trap_instr)
      pick = MIPU_SRC_TRAP;
    else if (mask_q)
      pick = MIPU_SRC_NONE;
    else if (ext_req)
      pick = MIPU_SRC_EXT;
    else if (tim16_req)
      pick = MIPU_SRC_TIM16;
    else if (tim8_req)
      pick = MIPU_SRC_TIM8;
    else if (key_req)
      pick = MIPU_SRC_KEY;
    else
      pick = MIPU_SRC_NONE;
  end

  function automatic logic [15:0] vec_of(input mipu_src_t s);
    case (s)
      MIPU_SRC_RESET: vec_of = MIPU_VEC_RESET;
      MIPU_SRC_TRAP: vec_of = MIPU_VEC_TRAP;
      MIPU_SRC_EXT: vec_of = MIPU_VEC_EXT;
      MIPU_SRC_TIM16: vec_of = MIPU_VEC_TIM16;
      MIPU_SRC_TIM8: vec_of = MIPU_VEC_TIM8;
      MIPU_SRC_KEY: vec_of = MIPU_VEC_KEY;
      default: vec_of = MIPU_VEC_RESET;
    endcase
  endfunction : vec_of

  // sequencer: one stack byte per cycle, no wait states on stack ram
  always_comb
  begin
    st_d = st_q;
    src_d = src_q;
    sp_d = sp_q;
    mask_d = mask_q;
    sb_d = '0;
    vec_d = vec_q;
    vf_d = 1'b0;
    rr_d = rr_q;
    rv_d = 1'b0;
    rst_d = 1'b0;
    rd_dly_d = stack_bus_q.rd;
    wake_d = cpu_waiting & tim16_req;
    case (st_q)
      MIPU_ST_RUN:
      begin
        if (reset_req)
        begin
          rst_d = 1'b1;
          sp_d = MIPU_SP_RESET;
          mask_d = 1'b1;
          src_d = MIPU_SRC_RESET;
          st_d = MIPU_ST_VEC_HI; // reset skips stacking
        end
        else if (insn_boundary && trap_return_instr)
          st_d = MIPU_ST_PULL_CC;
        else if (insn_boundary && pick != MIPU_SRC_NONE)
        begin
          src_d = pick;
          st_d = MIPU_ST_PC_LO;
        end
      end
      MIPU_ST_PC_LO, MIPU_ST_PC_HI, MIPU_ST_IDX, MIPU_ST_ACC, MIPU_ST_CC:
      begin
        sb_d.wr = 1'b1;
        sb_d.addr = MIPU_STACK_BASE | {2'b00, sp_q};
        sp_d = sp_q - 6'd1;
        case (st_q)
          MIPU_ST_PC_LO: begin sb_d.wdata = cpu_regs.pc[7:0]; st_d = MIPU_ST_PC_HI; end
          MIPU_ST_PC_HI: begin sb_d.wdata = cpu_regs.pc[15:8]; st_d = MIPU_ST_IDX; end
          MIPU_ST_IDX: begin sb_d.wdata = cpu_regs.idx; st_d = MIPU_ST_ACC; end
          MIPU_ST_ACC: begin sb_d.wdata = cpu_regs.acc; st_d = MIPU_ST_CC; end
          default: begin sb_d.wdata = cpu_regs.cc; st_d = MIPU_ST_MASK; end
        endcase
      end
      MIPU_ST_MASK:
      begin
        mask_d = 1'b1;
        st_d = MIPU_ST_VEC_HI;
      end
      MIPU_ST_VEC_HI:
      begin
        vec_d = vec_of(src_q);
        vf_d = 1'b1;
        st_d = MIPU_ST_VEC_LO;
      end
      MIPU_ST_VEC_LO:
      begin
        vec_d = vec_q + 16'd1;
        vf_d = 1'b1;
        st_d = MIPU_ST_DONE;
      end
      MIPU_ST_PULL_CC, MIPU_ST_PULL_ACC, MIPU_ST_PULL_IDX, MIPU_ST_PULL_HI, MIPU_ST_PULL_LO:
      begin
        sb_d.rd = 1'b1;
        sp_d = sp_q + 6'd1;
        sb_d.addr = MIPU_STACK_BASE | {2'b00, sp_d};
        case (st_q)
          MIPU_ST_PULL_CC: st_d = MIPU_ST_PULL_ACC;
          MIPU_ST_PULL_ACC: st_d = MIPU_ST_PULL_IDX;
          MIPU_ST_PULL_IDX: st_d = MIPU_ST_PULL_HI;
          MIPU_ST_PULL_HI: st_d = MIPU_ST_PULL_LO;
          default: st_d = MIPU_ST_DONE;
        endcase
      end
      MIPU_ST_DONE:
        st_d = MIPU_ST_RUN;
      default:
        st_d = MIPU_ST_RUN;
    endcase
    // stack ram registers the strobe, so data trails stack_bus_q.rd by one cycle
    // the last byte lands once the sequencer is back in run
    if (rd_dly_q)
    begin
      case (st_q)
        MIPU_ST_PULL_IDX:
        begin
          rr_d.cc = stack_rdata;
          mask_d = stack_rdata[MIPU_CC_MASK_BIT];
        end
        MIPU_ST_PULL_HI: rr_d.acc = stack_rdata;
        MIPU_ST_PULL_LO: rr_d.idx = stack_rdata;
        MIPU_ST_DONE: rr_d.pc[15:8] = stack_rdata;
        default:
        begin
          rr_d.pc[7:0] = stack_rdata;
          rv_d = 1'b1;
        end
      endcase
    end
    if (reset_req)
      rst_d = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= MIPU_ST_RUN;
      src_q <= MIPU_SRC_NONE;
      sp_q <= MIPU_SP_RESET;
      mask_q <= 1'b1;
      stack_bus_q <= '0;
      vec_q <= MIPU_VEC_RESET;
      vector_fetch_q <= 1'b0;
      restore_regs_q <= '0;
      rr_q <= '0;
      restore_valid_q <= 1'b0;
      rst_q <= 1'b0;
      rd_dly_q <= 1'b0;
      wake_q <= 1'b0;
      seq_busy_q <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      reg_rdata <= 8'h00;
      compare_pin_enable <= 1'b0;
      capture_pin_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      src_q <= src_d;
      sp_q <= sp_d;
      mask_q <= mask_d;
      stack_bus_q <= sb_d;
      vec_q <= vec_d;
      vector_fetch_q <= vf_d;
      rr_q <= rr_d;
      restore_regs_q <= rr_d;
      restore_valid_q <= rv_d;
      rst_q <= rst_d;
      rd_dly_q <= rd_dly_d;
      wake_q <= wake_d;
      seq_busy_q <= st_d != MIPU_ST_RUN;
      // open drain: only drives low as indicator when interrupt use is off
      pin_oe <= ~mcs_d[MIPU_BIT_EXT_EN] & mcs_d[MIPU_BIT_LED];
      pin_out <= 1'b0;
      reg_rdata <= rdata_d;
      compare_pin_enable <= mcs_d[MIPU_BIT_CMP_PIN];
      capture_pin_enable <= mcs_d[MIPU_BIT_CAP_PIN];
    end
  end

  assign vector_addr_q = vec_q;
  assign int_mask_q = mask_q;
  assign cpu_reset_q = rst_q;

  sequence entry_push_s;
    st_q == MIPU_ST_PC_LO ##1 st_q == MIPU_ST_PC_HI ##1 st_q == MIPU_ST_IDX;
  endsequence
  sequence entry_tail_s;
    st_q == MIPU_ST_ACC ##1 st_q == MIPU_ST_CC ##1 st_q == MIPU_ST_MASK ##1 st_q == MIPU_ST_VEC_HI;
  endsequence

  entry_order_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (st_q == MIPU_ST_RUN && st_d == MIPU_ST_PC_LO) |=> entry_push_s ##1 entry_tail_s)
    else $error("entry sequence out of order");
  push_order_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (st_q == MIPU_ST_PC_LO) |=> stack_bus_q.wr && stack_bus_q.wdata == $past(cpu_regs.pc[7:0]))
    else $error("first push not pc low");
  mask_set_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (st_q == MIPU_ST_MASK) |=> mask_q && st_q == MIPU_ST_VEC_HI)
    else $error("mask not set before vector");
  pull_order_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (st_q == MIPU_ST_PULL_CC) |=> st_q == MIPU_ST_PULL_ACC ##1 st_q == MIPU_ST_PULL_IDX)
    else $error("pull order wrong");
  trap_vec_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (st_q == MIPU_ST_VEC_HI && src_q == MIPU_SRC_TRAP) |=> vector_addr_q == MIPU_VEC_TRAP && vector_fetch_q)
    else $error("trap vector wrong");
  reset_top_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (reset_req && st_q == MIPU_ST_RUN)
    |=> st_q == MIPU_ST_VEC_HI && src_q == MIPU_SRC_RESET && mask_q && cpu_reset_q)
    else $error("reset not top priority");
  trap_unmasked_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (insn_boundary && soft_trap_instr && !trap_return_instr && !reset_req && st_q == MIPU_ST_RUN)
    |=> st_q == MIPU_ST_PC_LO && src_q == MIPU_SRC_TRAP)
    else $error("trap blocked");
  mask_blocks_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (insn_boundary && mask_q && !soft_trap_instr && !trap_return_instr && !reset_req && st_q == MIPU_ST_RUN)
    |=> st_q == MIPU_ST_RUN)
    else $error("masked request taken");
  wake_follow_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (cpu_waiting && tim16_req) |=> wake_q)
    else $error("timer request did not wake");
  latch_clear_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (st_q == MIPU_ST_VEC_HI && src_q == MIPU_SRC_EXT && pin_in && !fall) |=> !ext_latch_q)
    else $error("pin latch not cleared");
  level_hold_a: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
    (ext_en && !sense && !pin_in) |=> ext_latch_q)
    else $error("level request lost");
  mcs_reset_a: assert property (@(posedge clk)
    !reset_n |-> mcs_q == MIPU_MCS_RESET)
    else $error("control register not cleared");
endmodule : mipu_core
`default_nettype wire

// File: mipu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mipu_cpu_model
  import mipu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire mipu_stack_bus_t stack_bus,
  output logic [7:0] stack_rdata
);
  logic [7:0] mem [0:255];
  // stack ram answers a read in the cycle after the strobe only
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      stack_rdata <= 8'h5a;
    else
    begin
      if (stack_bus.wr)
        mem[stack_bus.addr] <= stack_bus.wdata;
      if (stack_bus.rd)
        stack_rdata <= mem[stack_bus.addr];
      else
        stack_rdata <= ~stack_rdata; // released bus toggles so stale data never looks valid
    end
  end
endmodule : mipu_cpu_model
`default_nettype wire

// File: mipu_pkg.sv
package mipu_pkg;
  localparam logic [7:0] MIPU_MCS_OFFSET = 8'h1c;
  localparam logic [7:0] MIPU_MCS_RESET = 8'h00;
  localparam int MIPU_BIT_EXT_EN = 7;
  localparam int MIPU_BIT_SENSE = 6;
  localparam int MIPU_BIT_CMP_PIN = 5;
  localparam int MIPU_BIT_CAP_PIN = 4;
  localparam int MIPU_BIT_LED = 2;
  localparam int MIPU_BIT_WDOG = 1;
  localparam int MIPU_BIT_POR = 0;
  localparam logic [7:0] MIPU_MCS_WMASK = 8'hf6;
  localparam logic [15:0] MIPU_VEC_RESET = 16'h1ffe;
  localparam logic [15:0] MIPU_VEC_TRAP = 16'h1ffc;
  localparam logic [15:0] MIPU_VEC_EXT = 16'h1ffa;
  localparam logic [15:0] MIPU_VEC_TIM16 = 16'h1ff8;
  localparam logic [15:0] MIPU_VEC_TIM8 = 16'h1ff6;
  localparam logic [15:0] MIPU_VEC_KEY = 16'h1ff4;
  localparam logic [7:0] MIPU_STACK_BASE = 8'hc0;
  localparam logic [5:0] MIPU_SP_RESET = 6'h3f;
  localparam int MIPU_KEY_LINES = 4;
  localparam int MIPU_CC_MASK_BIT = 3;

  typedef enum logic [2:0] {
    MIPU_SRC_NONE, MIPU_SRC_RESET, MIPU_SRC_TRAP, MIPU_SRC_EXT, MIPU_SRC_TIM16, MIPU_SRC_TIM8, MIPU_SRC_KEY
  } mipu_src_t;

  typedef enum logic [3:0] {
    MIPU_ST_RUN, MIPU_ST_PC_LO, MIPU_ST_PC_HI, MIPU_ST_IDX, MIPU_ST_ACC, MIPU_ST_CC, MIPU_ST_MASK,
    MIPU_ST_VEC_HI, MIPU_ST_VEC_LO, MIPU_ST_PULL_CC, MIPU_ST_PULL_ACC, MIPU_ST_PULL_IDX,
    MIPU_ST_PULL_HI, MIPU_ST_PULL_LO, MIPU_ST_DONE
  } mipu_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] idx;
    logic [7:0] acc;
    logic [7:0] cc;
  } mipu_cpu_regs_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mipu_stack_bus_t;

  typedef struct packed {
    logic capture_flag;
    logic capture_int_enable;
    logic compare_flag;
    logic compare_int_enable;
    logic overflow_flag;
    logic overflow_int_enable;
    logic short_timer_flag;
    logic short_timer_int_enable;
  } mipu_timer_src_t;
endpackage : mipu_pkg

// File: tb_mipu_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mipu_core;
  import mipu_pkg::*;
  logic clk, reset_n, clk_en, reg_wr, reg_rd, pin_in, watchdog_expired, power_on_event, pin_reset_req;
  logic insn_boundary, soft_trap_instr, trap_return_instr, cpu_waiting, mw, mv, mr;
  logic pin_out, pin_oe, vector_fetch_q, int_mask_q, seq_busy_q, wake_q, restore_valid_q, cpu_reset_q;
  logic compare_pin_enable, capture_pin_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, stack_rdata, rv;
  logic [3:0] key_line_flag, key_line_int_enable;
  logic [15:0] vector_addr_q;
  mipu_timer_src_t timer_src;
  mipu_cpu_regs_t cpu_regs, restore_regs_q;
  mipu_stack_bus_t stack_bus_q;
  int miscompares, n_checks, sp;
  logic [7:0] wq[$], aq[$];
  logic [15:0] vq[$];
  mipu_cpu_regs_t stk[$];

  mipu_core #(.KEY_LINES(4)) mipu_core_inst (.clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_in, .pin_out, .pin_oe, .timer_src, .key_line_flag, .key_line_int_enable, .watchdog_expired,
    .power_on_event, .pin_reset_req, .insn_boundary, .soft_trap_instr, .trap_return_instr, .cpu_waiting, .cpu_regs,
    .stack_rdata, .stack_bus_q, .vector_addr_q, .vector_fetch_q, .int_mask_q, .seq_busy_q, .wake_q,
    .restore_regs_q, .restore_valid_q, .cpu_reset_q, .compare_pin_enable, .capture_pin_enable);
  mipu_cpu_model mipu_cpu_model_inst (.clk, .reset_n, .stack_bus(stack_bus_q), .stack_rdata);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // each registered output is seen once per cycle, before the edge updates it
  always @(posedge clk)
  begin
    if (stack_bus_q.wr === 1'b1)
    begin
      wq.push_back(stack_bus_q.wdata);
      aq.push_back(stack_bus_q.addr);
      mw = mw | int_mask_q;
    end
    if (vector_fetch_q === 1'b1)
    begin
      vq.push_back(vector_addr_q);
      mv = mv & int_mask_q;
    end
    if (cpu_reset_q === 1'b1)
      mr = 1'b1;
  end

  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rv = reg_rdata;
  endtask : rd

  // c: bit0 trap, bit1 reset pin, bit2 watchdog; vec 0 means no entry expected
  task automatic try(input logic [15:0] vec, input logic [2:0] c);
    int k;
    logic m0;
    logic [7:0] eb [5];
    mipu_cpu_regs_t r;
    r = mipu_cpu_regs_t'({$urandom, 8'($urandom)});
    r.cc[3] = 1'b0;
    eb = '{r.pc[7:0], r.pc[15:8], r.idx, r.acc, r.cc};
    m0 = int_mask_q;
    wq.delete();
    aq.delete();
    vq.delete();
    mw = 1'b0;
    mv = 1'b1;
    mr = 1'b0;
    @(posedge clk);
    cpu_regs <= r;
    insn_boundary <= 1'b1;
    soft_trap_instr <= c[0];
    pin_reset_req <= c[1];
    watchdog_expired <= c[2];
    @(posedge clk);
    insn_boundary <= 1'b0;
    soft_trap_instr <= 1'b0;
    pin_reset_req <= 1'b0;
    watchdog_expired <= 1'b0;
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk);
      if (k > 0 && seq_busy_q !== 1'b1) break;
    end
    repeat (2) @(posedge clk);
    if (vec == 16'h0)
    begin
      chk(16'(vq.size() + wq.size()), 16'h0);
      chk({15'h0, mr}, 16'h0);
    end
    else
    begin
      chk(16'(vq.size()), 16'h2);
      chk(vq[0], vec);
      chk(vq[1], 16'(vec + 16'h1));
      chk({15'h0, mv}, 16'h1);
      if (vec != MIPU_VEC_RESET)
      begin
        chk(16'(wq.size()), 16'h5);
        chk({15'h0, mr}, 16'h0);
        for (k = 0; k < 5; k++)
        begin
          chk(16'(wq[k]), 16'(eb[k]));
          chk(16'(aq[k]), 16'(MIPU_STACK_BASE | 8'((sp - k) & 63)));
        end
        if (!m0)
          chk({15'h0, mw}, 16'h0);
        sp -= 5;
        stk.push_back(r);
      end
      else
      begin
        chk(16'(wq.size()), 16'h0);
        chk({15'h0, mr}, 16'h1);
        sp = 63;
        stk.delete();
      end
    end
  endtask : try

  task automatic ret();
    int k;
    mipu_cpu_regs_t r;
    r = stk.pop_back();
    @(posedge clk);
    insn_boundary <= 1'b1;
    trap_return_instr <= 1'b1;
    @(posedge clk);
    insn_boundary <= 1'b0;
    trap_return_instr <= 1'b0;
    for (k = 0; k < 40 && restore_valid_q !== 1'b1; k++) @(posedge clk);
    chk(restore_regs_q.pc, r.pc);
    chk({restore_regs_q.idx, restore_regs_q.acc}, {r.idx, r.acc});
    chk(16'(restore_regs_q.cc), 16'(r.cc));
    for (k = 0; k < 40 && seq_busy_q !== 1'b0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk({15'h0, int_mask_q}, {15'h0, r.cc[3]});
    sp += 5;
  endtask : ret

  initial
  begin
    #500000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    {reset_n, reg_wr, reg_rd, pin_in, watchdog_expired, power_on_event, pin_reset_req} = 7'h08;
    {insn_boundary, soft_trap_instr, trap_return_instr, cpu_waiting} = 4'h0;
    {reg_addr, reg_wdata, key_line_flag, key_line_int_enable} = 24'h0;
    clk_en = 1'b1;
    timer_src = '0;
    cpu_regs = '0;
    sp = 63;
    void'($urandom(15331));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(MIPU_MCS_OFFSET);
    chk(16'(rv), 16'h0);
    chk({15'h0, int_mask_q}, 16'h1);
    rd(8'h1d);
    chk(16'(rv), 16'h0);
    wr(MIPU_MCS_OFFSET, 8'hff);
    rd(MIPU_MCS_OFFSET);
    chk(16'(rv), 16'hf6);
    chk({14'h0, compare_pin_enable, capture_pin_enable}, 16'h3);
    chk({15'h0, pin_oe}, 16'h0);
    wr(MIPU_MCS_OFFSET, 8'h04);
    @(posedge clk);
    power_on_event <= 1'b1;
    @(posedge clk);
    power_on_event <= 1'b0;
    rd(MIPU_MCS_OFFSET);
    chk(16'(rv), 16'h05);
    chk({15'h0, pin_oe}, 16'h1);
    chk({15'h0, pin_out}, 16'h0);
    timer_src <= mipu_timer_src_t'(8'h20);
    cpu_waiting <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'h0, wake_q}, 16'h0);
    timer_src <= mipu_timer_src_t'(8'h30);
    repeat (3) @(posedge clk);
    chk({15'h0, wake_q}, 16'h1);
    cpu_waiting <= 1'b0;
    timer_src <= '0;
    try(MIPU_VEC_TRAP, 3'h1);
    ret();
    wr(MIPU_MCS_OFFSET, 8'h80);
    pin_in <= 1'b0;
    timer_src <= mipu_timer_src_t'(8'hff);
    key_line_flag <= 4'hf;
    key_line_int_enable <= 4'hf;
    try(MIPU_VEC_EXT, 3'h0);
    ret();
    try(MIPU_VEC_EXT, 3'h0);
    pin_in <= 1'b1;
    ret();
    try(MIPU_VEC_EXT, 3'h0);
    ret();
    for (int i = 0; i < 3; i++)
    begin
      timer_src <= mipu_timer_src_t'(8'((8'h40 >> (2 * i)) | 8'hab));
      try(MIPU_VEC_TIM16, 3'h0);
      ret();
    end
    timer_src <= mipu_timer_src_t'(8'hab);
    try(MIPU_VEC_TIM8, 3'h0);
    ret();
    timer_src <= mipu_timer_src_t'(8'haa);
    for (int i = 0; i < 4; i++)
    begin
      key_line_int_enable <= 4'(1 << i);
      try(MIPU_VEC_KEY, 3'h0);
      ret();
    end
    key_line_int_enable <= 4'h0;
    try(16'h0, 3'h0);
    wr(MIPU_MCS_OFFSET, 8'hc0);
    pin_in <= 1'b0;
    try(MIPU_VEC_EXT, 3'h0);
    ret();
    try(16'h0, 3'h0);
    pin_in <= 1'b1;
    try(MIPU_VEC_TRAP, 3'h1);
    pin_in <= 1'b0;
    try(16'h0, 3'h0);
    ret();
    try(MIPU_VEC_EXT, 3'h0);
    ret();
    wr(MIPU_MCS_OFFSET, 8'h40);
    try(16'h0, 3'h0);
    try(16'h0, 3'h4);
    wr(MIPU_MCS_OFFSET, 8'h02);
    try(MIPU_VEC_RESET, 3'h4);
    try(MIPU_VEC_RESET, 3'h2);
    // a write while the clock enable is low must leave the register untouched
    clk_en <= 1'b0;
    wr(MIPU_MCS_OFFSET, 8'h00);
    clk_en <= 1'b1;
    rd(MIPU_MCS_OFFSET);
    chk(16'(rv), 16'h02);
    complete_run();
  end
endmodule : tb_mipu_core
`default_nettype wire
